// ---- core/ipcr_pkg.sv ----
/*
 package for the input programmable-gain configuration registers: offsets, field positions,
 reset values, mode codes, the line gain lookup table and the mic gain constants.
 assumes a plain register port with byte-wide data and byte addresses.
*/
package ipcr_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RIGHT_INPUT_GAIN_CTRL_OFS = 8'h2d;
   localparam logic [7:0] LEFT_INPUT_CONFIG_OFS     = 8'h2e;
   localparam logic [7:0] RIGHT_INPUT_CONFIG_OFS    = 8'h2f;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SILENCE_BIT = 7;
   localparam int GAIN_LSB    = 0;
   localparam int GAIN_W      = 5;
   localparam int CMR_BIT     = 6;
   localparam int MINUS_LSB   = 4;
   localparam int PLUS_LSB    = 2;
   localparam int MODE_LSB    = 0;
   localparam int SEL_W       = 2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic       SILENCE_RST = 1'h1;
   localparam logic [4:0] GAIN_RST    = 5'h05;
   localparam logic       CMR_RST     = 1'h1;
   localparam logic [1:0] MINUS_RST   = 2'h0;
   localparam logic [1:0] PLUS_RST    = 2'h1;
   localparam logic [1:0] MODE_RST    = 2'h0;

   // ----------------------------------------------------------------
   // codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_SINGLE    = 2'h0;
   localparam logic [1:0] MODE_DIFF_LINE = 2'h1;
   localparam logic [1:0] MODE_DIFF_MIC  = 2'h2;
   localparam logic [1:0] MODE_RESERVED  = 2'h3;

   // one-hot pin selections: one, two, three
   localparam logic [2:0] PIN_ONE   = 3'h1;
   localparam logic [2:0] PIN_TWO   = 3'h2;
   localparam logic [2:0] PIN_THREE = 3'h4;

   // gain in tenths of a dB, signed
   localparam int GAIN_DB_W = 10;
   localparam logic [4:0] MIC_CODE_RESERVED = 5'h00;
   localparam logic [4:0] MIC_CODE_TOP      = 5'h07;
   localparam logic signed [9:0] MIC_GAIN_BASE = 10'sd90;
   localparam logic signed [9:0] MIC_GAIN_STEP = 10'sd30;
   localparam logic signed [9:0] MIC_GAIN_TOP  = 10'sd300;

   typedef logic signed [GAIN_DB_W-1:0] ipcr_gain_t;

   // single-ended and differential-line table, -1.5 dB to +28.3 dB
   localparam ipcr_gain_t LINE_GAIN [32] = '{
      -10'sd15, -10'sd13, -10'sd10, -10'sd7, -10'sd3, 10'sd0, 10'sd3, 10'sd7,
      10'sd10, 10'sd14, 10'sd18, 10'sd23, 10'sd27, 10'sd32, 10'sd37, 10'sd42,
      10'sd48, 10'sd54, 10'sd60, 10'sd67, 10'sd75, 10'sd83, 10'sd92, 10'sd102,
      10'sd114, 10'sd127, 10'sd143, 10'sd162, 10'sd192, 10'sd223, 10'sd252, 10'sd283
   };

endpackage

// ---- core/ipcr_gain_decode.sv ----
/*
 gain decoder: turns the 5-bit gain code and the input mode into a gain in tenths of a dB.
 assumes the code and mode come from registers on the same clock; purely combinational.
*/
`timescale 1ns/10ps
module ipcr_gain_decode (
   input  wire logic [4:0]          gain_code,
   input  wire logic [1:0]          mode,
   output      ipcr_pkg::ipcr_gain_t gain_tenth_db,
   output      logic                code_reserved
);

   always_comb begin
      gain_tenth_db = ipcr_pkg::LINE_GAIN[gain_code];
      code_reserved = 1'b0;
      if (mode == ipcr_pkg::MODE_DIFF_MIC) begin
         if (gain_code == ipcr_pkg::MIC_CODE_RESERVED) begin
            // reserved code: hold the lowest mic step so the stage never sees nonsense
            gain_tenth_db = ipcr_pkg::MIC_GAIN_BASE + ipcr_pkg::MIC_GAIN_STEP;
            code_reserved = 1'b1;
         end else if (gain_code >= ipcr_pkg::MIC_CODE_TOP) begin
            gain_tenth_db = ipcr_pkg::MIC_GAIN_TOP;
         end else begin
            gain_tenth_db = ipcr_pkg::ipcr_gain_t'(ipcr_pkg::MIC_GAIN_BASE
                            + ipcr_pkg::MIC_GAIN_STEP * $signed({5'h00, gain_code}));
         end
      end else if (mode == ipcr_pkg::MODE_RESERVED) begin
         code_reserved = 1'b1;
      end
   end

endmodule

// ---- core/ipcr_pin_decode.sv ----
/*
 pin selector decoder: turns a 2-bit pin select field into a one-hot choice of three pins.
 assumes the field comes from a register on the same clock; purely combinational.
*/
`timescale 1ns/10ps
module ipcr_pin_decode (
   input  wire logic [1:0] sel,
   output      logic [2:0] pin_onehot
);

   always_comb begin
      // 1x both pick the third pin
      if (sel[1]) begin
         pin_onehot = ipcr_pkg::PIN_THREE;
      end else if (sel[0]) begin
         pin_onehot = ipcr_pkg::PIN_TWO;
      end else begin
         pin_onehot = ipcr_pkg::PIN_ONE;
      end
   end

endmodule

// ---- core/ipcr_input_pga_config_regs.sv ----
/*
 register bank for the analogue input gain stage: right gain and silence, left input
 configuration, and the right input mode that steers the right gain decode.
 assumes a single-clock software port with a one-cycle read latency; outputs drive the
 analogue stage directly from flip-flops.
*/
// Decided for this implementation: the plain strobed port.
// How it works
// - right gain register bit 7 silences right amplifier; resets to silenced.
// - line or single-ended mode: five-bit gain follows table, -1.5 to +28.3 dB.
// - mic mode: code 0 reserved, 1..6 give +12..+27 dB, rest +30 dB.
// - right gain code resets to 00101: 0 dB line, +24 dB mic.
// - left bit 6 enables common rejection, reset 1, active only in line mode.
// - left bits 5:4 choose minus pin, swap role in mic mode, reset 00.
// - left bits 3:2 choose plus pin, swap role in mic mode, reset 01.
// - left bits 1:0 select mode; 11 reserved, software must not write it.
// - right mode comes from separate two-bit field, same coding as left.
`timescale 1ns/10ps
module ipcr_input_pga_config_regs (
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic [7:0]              addr,
   input  wire logic [7:0]              wdata,
   input  wire logic                    wr_en,
   input  wire logic                    rd_en,
   output      logic [7:0]              rdata,
   output      logic                    right_pga_silence,
   output      logic signed [9:0]       right_gain_tenth_db,
   output      logic                    right_gain_reserved,
   output      logic                    left_common_rejection_en,
   output      logic [2:0]              left_inv_pin,
   output      logic [2:0]              left_noninv_pin,
   output      logic [1:0]              left_mode,
   output      logic                    left_mode_reserved
);

   // ----------------------------------------------------------------
   // register fields
   // ----------------------------------------------------------------
   logic       right_pga_silence_q;
   logic [4:0] right_pga_gain_q;
   logic       left_common_rejection_en_q;
   logic [1:0] left_minus_pin_sel_q;
   logic [1:0] left_plus_pin_sel_q;
   logic [1:0] left_mode_q;
   logic [1:0] right_mode_q;
   logic [7:0] rdata_d;

   logic signed [9:0] gain_dec;
   logic              gain_res;
   logic [2:0]        minus_pin;
   logic [2:0]        plus_pin;

   logic wr_right_gain;
   logic wr_left_cfg;
   logic wr_right_cfg;

   assign wr_right_gain = wr_en && (addr == ipcr_pkg::RIGHT_INPUT_GAIN_CTRL_OFS);
   assign wr_left_cfg   = wr_en && (addr == ipcr_pkg::LEFT_INPUT_CONFIG_OFS);
   assign wr_right_cfg  = wr_en && (addr == ipcr_pkg::RIGHT_INPUT_CONFIG_OFS);

   // ----------------------------------------------------------------
   // right gain register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         right_pga_silence_q <= ipcr_pkg::SILENCE_RST;
         right_pga_gain_q    <= ipcr_pkg::GAIN_RST;
      end else if (wr_right_gain) begin
         right_pga_silence_q <= wdata[ipcr_pkg::SILENCE_BIT];
         right_pga_gain_q    <= wdata[ipcr_pkg::GAIN_LSB +: ipcr_pkg::GAIN_W];
      end
   end

   // ----------------------------------------------------------------
   // left configuration register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         left_common_rejection_en_q <= ipcr_pkg::CMR_RST;
         left_minus_pin_sel_q       <= ipcr_pkg::MINUS_RST;
         left_plus_pin_sel_q        <= ipcr_pkg::PLUS_RST;
         left_mode_q                <= ipcr_pkg::MODE_RST;
      end else if (wr_left_cfg) begin
         left_common_rejection_en_q <= wdata[ipcr_pkg::CMR_BIT];
         left_minus_pin_sel_q       <= wdata[ipcr_pkg::MINUS_LSB +: ipcr_pkg::SEL_W];
         left_plus_pin_sel_q        <= wdata[ipcr_pkg::PLUS_LSB +: ipcr_pkg::SEL_W];
         // the reserved code is stored as written so software can see its mistake
         left_mode_q                <= wdata[ipcr_pkg::MODE_LSB +: ipcr_pkg::SEL_W];
      end
   end

   // ----------------------------------------------------------------
   // right mode field, only the mode bits live here
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         right_mode_q <= ipcr_pkg::MODE_RST;
      end else if (wr_right_cfg) begin
         right_mode_q <= wdata[ipcr_pkg::MODE_LSB +: ipcr_pkg::SEL_W];
      end
   end

   // ----------------------------------------------------------------
   // decoders
   // ----------------------------------------------------------------
   ipcr_gain_decode u_gain (
      .gain_code     (right_pga_gain_q),
      .mode          (right_mode_q),
      .gain_tenth_db (gain_dec),
      .code_reserved (gain_res)
   );

   ipcr_pin_decode u_minus (
      .sel        (left_minus_pin_sel_q),
      .pin_onehot (minus_pin)
   );

   ipcr_pin_decode u_plus (
      .sel        (left_plus_pin_sel_q),
      .pin_onehot (plus_pin)
   );

   // ----------------------------------------------------------------
   // outputs to the analogue stage, registered
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         right_pga_silence   <= ipcr_pkg::SILENCE_RST;
         right_gain_tenth_db <= ipcr_pkg::LINE_GAIN[ipcr_pkg::GAIN_RST];
         right_gain_reserved <= 1'b0;
      end else begin
         right_pga_silence   <= right_pga_silence_q;
         right_gain_tenth_db <= gain_dec;
         right_gain_reserved <= gain_res;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         left_common_rejection_en <= 1'b0;
         left_inv_pin             <= ipcr_pkg::PIN_ONE;
         left_noninv_pin          <= ipcr_pkg::PIN_TWO;
         left_mode                <= ipcr_pkg::MODE_RST;
         left_mode_reserved       <= 1'b0;
      end else begin
         // rejection only has meaning in differential-line mode
         left_common_rejection_en <= left_common_rejection_en_q
                                     && (left_mode_q == ipcr_pkg::MODE_DIFF_LINE);
         left_mode                <= left_mode_q;
         left_mode_reserved       <= (left_mode_q == ipcr_pkg::MODE_RESERVED);
         if (left_mode_q == ipcr_pkg::MODE_DIFF_MIC) begin
            // mic mode swaps which side each select field drives
            left_noninv_pin <= minus_pin;
            left_inv_pin    <= plus_pin;
         end else begin
            left_inv_pin    <= minus_pin;
            left_noninv_pin <= plus_pin;
         end
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      unique case (addr)
         ipcr_pkg::RIGHT_INPUT_GAIN_CTRL_OFS: begin
            rdata_d[ipcr_pkg::SILENCE_BIT] = right_pga_silence_q;
            rdata_d[ipcr_pkg::GAIN_LSB +: ipcr_pkg::GAIN_W] = right_pga_gain_q;
         end
         ipcr_pkg::LEFT_INPUT_CONFIG_OFS: begin
            rdata_d[ipcr_pkg::CMR_BIT] = left_common_rejection_en_q;
            rdata_d[ipcr_pkg::MINUS_LSB +: ipcr_pkg::SEL_W] = left_minus_pin_sel_q;
            rdata_d[ipcr_pkg::PLUS_LSB +: ipcr_pkg::SEL_W]  = left_plus_pin_sel_q;
            rdata_d[ipcr_pkg::MODE_LSB +: ipcr_pkg::SEL_W]  = left_mode_q;
         end
         ipcr_pkg::RIGHT_INPUT_CONFIG_OFS: begin
            rdata_d[ipcr_pkg::MODE_LSB +: ipcr_pkg::SEL_W] = right_mode_q;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         rdata <= rdata_d;
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule

// ---- testbench/ipcr_regs_props.sv ----
/*
 checker for the input gain configuration registers: write latency onto the analogue
 outputs, reset state and consistency of the decoded outputs.
 assumes it is bound to the register bank and sees only its ports.
*/
`timescale 1ns/10ps
module ipcr_regs_props (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic [7:0]        addr,
   input wire logic [7:0]        wdata,
   input wire logic              wr_en,
   input wire logic              rd_en,
   input wire logic [7:0]        rdata,
   input wire logic              right_pga_silence,
   input wire logic signed [9:0] right_gain_tenth_db,
   input wire logic              right_gain_reserved,
   input wire logic              left_common_rejection_en,
   input wire logic [2:0]        left_inv_pin,
   input wire logic [2:0]        left_noninv_pin,
   input wire logic [1:0]        left_mode,
   input wire logic              left_mode_reserved
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // assertions and cover points
   // ----------------------------------------------------------------
   a_reset_outputs: assert property ($past(rst) |-> right_pga_silence
      && right_gain_tenth_db == 10'sd0 && left_inv_pin == 3'h1 && left_noninv_pin == 3'h2)
      else $error("outputs wrong after reset");
   a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("read data outside read cycle");
   a_silence_write: assert property (wr_en && addr == 8'h2d |-> ##2
      right_pga_silence == $past(wdata[7], 2)) else $error("silence bit not applied");
   a_cmr_write: assert property (wr_en && addr == 8'h2e |-> ##2
      left_common_rejection_en == ($past(wdata[6], 2) && $past(wdata[1:0], 2) == 2'h1))
      else $error("rejection wrong");
   a_mode_write: assert property (wr_en && addr == 8'h2e |-> ##2
      left_mode == $past(wdata[1:0], 2)) else $error("left mode not applied");
   a_mode_flag: assert property (left_mode_reserved == (left_mode == 2'h3))
      else $error("reserved mode flag wrong");
   a_pins_onehot: assert property ($onehot(left_inv_pin)
      && $onehot(left_noninv_pin)) else $error("pin choice not one-hot");
   a_gain_range: assert property (right_gain_tenth_db >= -10'sd15
      && right_gain_tenth_db <= 10'sd300) else $error("gain out of range");
   a_outputs_hold: assert property (!$past(wr_en) && !$past(wr_en, 2) |->
      $stable({right_pga_silence, right_gain_tenth_db, right_gain_reserved, left_inv_pin,
      left_noninv_pin, left_common_rejection_en, left_mode})) else $error("output moved");
   c_right_write: cover property (wr_en && addr == 8'h2d);
   c_left_write: cover property (wr_en && addr == 8'h2e);
   c_mic_reserved: cover property (right_gain_reserved);
   c_rejection_on: cover property (left_common_rejection_en);
endmodule
bind ipcr_input_pga_config_regs ipcr_regs_props u_props (.ref_clk(ref_clk), .rst(rst),
   .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
   .right_pga_silence(right_pga_silence), .right_gain_tenth_db(right_gain_tenth_db),
   .right_gain_reserved(right_gain_reserved), .left_mode(left_mode),
   .left_common_rejection_en(left_common_rejection_en), .left_inv_pin(left_inv_pin),
   .left_noninv_pin(left_noninv_pin), .left_mode_reserved(left_mode_reserved));

// ---- testbench/testbench.sv ----
/*
 self-checking bench for the input gain configuration registers.
 assumes the register bank with a one-cycle read and outputs two edges after a write.
*/
`timescale 1ns/10ps
module testbench;
   // ----------------------------------------------------------------
   // signals and shadow state
   // ----------------------------------------------------------------
   localparam logic [7:0] MSK [3] = '{8'h9f, 8'h7f, 8'h03};
   localparam logic [7:0] RSTV [3] = '{8'h85, 8'h44, 8'h00};
   logic              ref_clk, rst, wr_en, rd_en, out_chk, rd_pend;
   logic [7:0]        addr, wdata, rdata;
   logic [7:0]        sh [3];
   logic [31:0]       r;
   logic [7:0]        rq [$];
   logic [21:0]       oq [$];
   logic              silence, g_res, cmr, m_res;
   logic signed [9:0] gain;
   logic [2:0]        inv, noninv;
   logic [1:0]        lmode;
   int                miscompares, samples_checked, cycles;
   ipcr_input_pga_config_regs dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .right_pga_silence(silence),
      .right_gain_tenth_db(gain), .right_gain_reserved(g_res), .left_common_rejection_en(cmr),
      .left_inv_pin(inv), .left_noninv_pin(noninv), .left_mode(lmode),
      .left_mode_reserved(m_res));
   // ----------------------------------------------------------------
   // expectations
   // ----------------------------------------------------------------
   function automatic logic [2:0] pin(input logic [1:0] s);
      return s[1] ? 3'h4 : (s[0] ? 3'h2 : 3'h1);
   endfunction
   function automatic logic [21:0] exp_out();
      logic [4:0]        c;
      logic signed [9:0] g;
      logic              mic, lmic;
      c = sh[0][4:0];
      mic = sh[2][1:0] == 2'h2;
      lmic = sh[1][1:0] == 2'h2;
      g = ipcr_pkg::LINE_GAIN[c];
      if (mic) begin
         // first step +12 dB, 3 dB steps, clamp at +30 dB; reserved code sits on the first step
         g = 10'sd120 + 10'sd30 * $signed({5'h00, c - 5'h01});
         if (c == 5'h00) g = 10'sd120;
         if (c >= 5'h07) g = 10'sd300;
      end
      return {sh[0][7], g, (mic && c == 5'h00) || sh[2][1:0] == 2'h3,
         sh[1][6] && sh[1][1:0] == 2'h1, lmic ? pin(sh[1][3:2]) : pin(sh[1][5:4]),
         lmic ? pin(sh[1][5:4]) : pin(sh[1][3:2]), sh[1][1:0], sh[1][1:0] == 2'h3};
   endfunction
   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   // strobes stay up after a call so back-to-back calls never assign them twice in one step;
   // chk and do_reset drop them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      if (a >= 8'h2d && a <= 8'h2f) sh[a - 8'h2d] = d & MSK[a - 8'h2d];
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      addr <= a;
      rd_en <= 1'b1;
      wr_en <= 1'b0;
      rq.push_back((a >= 8'h2d && a <= 8'h2f) ? sh[a - 8'h2d] : 8'h00);
      @(posedge ref_clk);
   endtask
   task automatic chk();
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge ref_clk);
      oq.push_back(exp_out());
      out_chk <= 1'b1;
      @(posedge ref_clk);
      out_chk <= 1'b0;
   endtask
   task automatic do_reset(input int n);
      rst <= 1'b1;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      sh = RSTV;
      repeat (n) @(posedge ref_clk);
      rst <= 1'b0;
   endtask
   // ----------------------------------------------------------------
   // comparison and verdict
   // ----------------------------------------------------------------
   task automatic cmp_rd(input logic [7:0] e);
      samples_checked++;
      if (rdata !== e) begin
         miscompares++;
         $display("unexpected read data at %0t: %h not %h", $time, rdata, e);
      end
   endtask
   task automatic cmp_out(input logic [21:0] e);
      samples_checked++;
      if ({silence, gain, g_res, cmr, inv, noninv, lmode, m_res} !== e) begin
         miscompares++;
         $display("unexpected outputs at %0t: want %h", $time, e);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // sampled at the falling edge so every registered output has settled
   always @(negedge ref_clk) begin
      if (rd_pend) cmp_rd(rq.pop_front());
      if (out_chk) cmp_out(oq.pop_front());
      rd_pend = rd_en;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      {out_chk, addr, wdata} = '0;
      miscompares = 0;
      samples_checked = 0;
      cycles = 0;
      void'($urandom(32'h629e));
      do_reset(12);
      for (int i = 0; i < 3; i++) rd(8'h2d + i[7:0]);
      chk();
      for (int m = 0; m < 4; m++) begin
         r = $urandom();
         wr(8'h2f, {r[7:2], m[1:0]});
         for (int c = 0; c < 32; c++) begin
            r = $urandom();
            wr(8'h2d, {r[7:5], c[4:0]});
            rd(8'h2d);
            chk();
         end
      end
      for (int i = 0; i < 64; i++) begin
         r = $urandom();
         wr(8'h2e, {r[1:0], i[5:0]});
         rd(8'h2e);
         chk();
      end
      wr(8'h30, 8'hff);
      wr(8'h2c, 8'hff);
      // neighbours read back too, so a stray write through an unmapped address shows up
      for (int i = 0; i < 5; i++) rd(8'h2c + i[7:0]);
      do_reset(2);
      for (int i = 0; i < 3; i++) rd(8'h2d + i[7:0]);
      chk();
      repeat (2) @(posedge ref_clk);
      complete_run();
   end
endmodule
